// ### logic/lac_pkg.sv
package lac_pkg;
	// channel count and register width
	localparam int NCH = 8;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	// register indices, byte address is four times the index
	localparam logic [5:0] IDX_LOS_STAT = 6'h04;
	localparam logic [5:0] IDX_DRV_STAT = 6'h05;
	localparam logic [5:0] IDX_LOS_IRQ_EN = 6'h06;
	localparam logic [5:0] IDX_DRV_IRQ_EN = 6'h07;
	localparam logic [5:0] IDX_LOS_IRQ = 6'h08;
	localparam logic [5:0] IDX_DRV_IRQ = 6'h09;
	localparam logic [5:0] IDX_SOFT_RST = 6'h0a;
	localparam logic [5:0] IDX_MON_SEL = 6'h0b;
	localparam logic [5:0] IDX_LOOPBACK = 6'h0c;
	localparam logic [5:0] IDX_ALARM_STD = 6'h0d;
	localparam logic [5:0] IDX_AUTO_ONES = 6'h0e;
	localparam logic [5:0] IDX_LINE_MODE = 6'h20;
	// field positions
	localparam int MON_TX_BIT = 3;
	localparam int MODE_E1_BIT = 0;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// bus states
	typedef enum logic [0:0] {
		LAC_WR_COLLECT = 1'b0,
		LAC_WR_RESP = 1'b1
	} lac_wr_st_t;
	typedef enum logic [0:0] {
		LAC_RD_IDLE = 1'b0,
		LAC_RD_RESP = 1'b1
	} lac_rd_st_t;
endpackage

// ### logic/lac_regs.sv
`timescale 1ns/1ps
// Summary of operation
// - driver-fail enable bits gate driver-fail interrupts
// - signal-loss status change sets its irq bit
// - signal-loss irq bits hold until cleared
// - driver-fail status change sets its irq bit
// - driver-fail irq bits hold until cleared
// - any soft reset write restores defaults
// - monitor codes 0000 and 1000 disable monitoring
// - low three bits pick channel, bit3 picks transmit
// - loopback bit n enables digital loopback channel n
// - line mode T1 ignores alarm standard bits
// - E1 one selects ETSI alarm criteria
// - E1 zero selects G.775 alarm criteria
// - auto all-ones starts on signal loss
// - all registers read zero after reset
// - enabled irq bits drive irq_n low
// - driver-fail status follows short detection
// - signal-loss status follows loss detection
module lac_regs
	import lac_pkg::*;
(
	input wire logic aclk, // clock, 250 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [7:0] awaddr, // write address
	input wire logic awvalid, // write address valid
	output logic awready, // write address ready
	input wire logic [31:0] wdata, // write data
	input wire logic [3:0] wstrb, // write strobes
	input wire logic wvalid, // write data valid
	output logic wready, // write data ready
	output logic [1:0] bresp, // write response
	output logic bvalid, // write response valid
	input wire logic bready, // write response ready
	input wire logic [7:0] araddr, // read address
	input wire logic arvalid, // read address valid
	output logic arready, // read address ready
	output logic [31:0] rdata, // read data
	output logic [1:0] rresp, // read response
	output logic rvalid, // read data valid
	input wire logic rready, // read data ready
	input wire logic [7:0] los_detect, // per-channel loss detector, async
	input wire logic [7:0] short_detect, // per-channel driver short detector, async
	input wire logic [7:0] tx_data_in, // per-channel transmit bits, aclk domain
	output logic [7:0] tx_data_out, // transmit bits after all-ones insertion
	output logic irq_n, // interrupt, active low
	output logic [7:0] loopback_en, // digital loopback per channel
	output logic [7:0] alarm_ets_sel, // ETSI criteria per channel, else G.775
	output logic alarm_t1_crit, // T1.231 criteria in force
	output logic [7:0] all_ones_active, // all-ones generation per channel
	output logic monitor_en, // monitor path enabled
	output logic monitor_tx, // monitor transmit path, else receive
	output logic [2:0] monitor_ch // monitored channel
);

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	logic [7:0] los_s1_q, los_s2_q, los_s3_q, los_s1_d, los_s2_d, los_s3_d;
	logic [7:0] drv_s1_q, drv_s2_q, drv_s3_q, drv_s1_d, drv_s2_d, drv_s3_d;

	// three-stage shift of both detector buses
	always_comb begin
		los_s1_d = los_detect;
		los_s2_d = los_s1_q;
		los_s3_d = los_s2_q;
		drv_s1_d = short_detect;
		drv_s2_d = drv_s1_q;
		drv_s3_d = drv_s2_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			los_s1_q <= REG_RST;
			los_s2_q <= REG_RST;
			los_s3_q <= REG_RST;
			drv_s1_q <= REG_RST;
			drv_s2_q <= REG_RST;
			drv_s3_q <= REG_RST;
		end else begin
			los_s1_q <= los_s1_d;
			los_s2_q <= los_s2_d;
			los_s3_q <= los_s3_d;
			drv_s1_q <= drv_s1_d;
			drv_s2_q <= drv_s2_d;
			drv_s3_q <= drv_s3_d;
		end
	end

	// ----------------------------------------
	// bus slave
	// ----------------------------------------
	lac_wr_st_t wr_st_q, wr_st_d;
	lac_rd_st_t rd_st_q, rd_st_d;
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0] aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d;
	logic [3:0] w_strb_q, w_strb_d;
	logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
	logic [1:0] bresp_d, rresp_d;
	logic [31:0] rdata_d;
	logic wr_fire, rd_take, soft_rst;
	logic [5:0] wr_idx, rd_idx;

	// register state, declared here for the read mux
	logic [7:0] los_stat_q, los_stat_d, drv_stat_q, drv_stat_d;
	logic [7:0] los_en_q, los_en_d, drv_en_q, drv_en_d;
	logic [7:0] los_irq_q, los_irq_d, drv_irq_q, drv_irq_d;
	logic [3:0] mon_sel_q, mon_sel_d;
	logic [7:0] loop_q, loop_d, std_q, std_d, ones_q, ones_d;
	logic e1_q, e1_d;

	function automatic logic idx_ok(input logic [5:0] i);
		idx_ok = (i >= IDX_LOS_STAT && i <= IDX_AUTO_ONES) || i == IDX_LINE_MODE;
	endfunction

	assign wr_idx = aw_addr_q[7:2];
	assign rd_idx = araddr[7:2];
	assign wr_fire = (wr_st_q == LAC_WR_COLLECT) && aw_full_q && w_full_q;
	assign rd_take = arvalid && arready;
	assign soft_rst = wr_fire && wr_idx == IDX_SOFT_RST;

	// address and data taken in either order, response after both
	always_comb begin
		wr_st_d = wr_st_q;
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid;
		bresp_d = bresp;
		if (awvalid && awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_full_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		case (wr_st_q)
			LAC_WR_COLLECT: begin
				if (wr_fire) begin
					wr_st_d = LAC_WR_RESP;
					bvalid_d = 1'b1;
					bresp_d = idx_ok(wr_idx) ? RESP_OKAY : RESP_SLVERR;
					aw_full_d = 1'b0;
					w_full_d = 1'b0;
				end
			end
			LAC_WR_RESP: begin
				if (bready) begin
					wr_st_d = LAC_WR_COLLECT;
					bvalid_d = 1'b0;
				end
			end
			default: wr_st_d = LAC_WR_COLLECT;
		endcase
		awready_d = (wr_st_d == LAC_WR_COLLECT) && !aw_full_d;
		wready_d = (wr_st_d == LAC_WR_COLLECT) && !w_full_d;
	end

	// read: one word per address, answered the cycle after it is taken
	always_comb begin
		rd_st_d = rd_st_q;
		rvalid_d = rvalid;
		rdata_d = rdata;
		rresp_d = rresp;
		case (rd_st_q)
			LAC_RD_IDLE: begin
				if (rd_take) begin
					rd_st_d = LAC_RD_RESP;
					rvalid_d = 1'b1;
					rresp_d = idx_ok(rd_idx) ? RESP_OKAY : RESP_SLVERR;
					rdata_d = WORD_RST;
					case (rd_idx)
						IDX_LOS_STAT: rdata_d[7:0] = los_stat_q;
						IDX_DRV_STAT: rdata_d[7:0] = drv_stat_q;
						IDX_LOS_IRQ_EN: rdata_d[7:0] = los_en_q;
						IDX_DRV_IRQ_EN: rdata_d[7:0] = drv_en_q;
						IDX_LOS_IRQ: rdata_d[7:0] = los_irq_q;
						IDX_DRV_IRQ: rdata_d[7:0] = drv_irq_q;
						IDX_MON_SEL: rdata_d[3:0] = mon_sel_q;
						IDX_LOOPBACK: rdata_d[7:0] = loop_q;
						IDX_ALARM_STD: rdata_d[7:0] = std_q;
						IDX_AUTO_ONES: rdata_d[7:0] = ones_q;
						IDX_LINE_MODE: rdata_d[MODE_E1_BIT] = e1_q;
						default: rdata_d = WORD_RST;
					endcase
				end
			end
			LAC_RD_RESP: begin
				if (rready) begin
					rd_st_d = LAC_RD_IDLE;
					rvalid_d = 1'b0;
				end
			end
			default: rd_st_d = LAC_RD_IDLE;
		endcase
		arready_d = rd_st_d == LAC_RD_IDLE;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_st_q <= LAC_WR_COLLECT;
			rd_st_q <= LAC_RD_IDLE;
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= REG_RST;
			w_data_q <= WORD_RST;
			w_strb_q <= 4'h0;
			awready <= 1'b1;
			wready <= 1'b1;
			bvalid <= 1'b0;
			bresp <= RESP_OKAY;
			arready <= 1'b1;
			rvalid <= 1'b0;
			rdata <= WORD_RST;
			rresp <= RESP_OKAY;
		end else begin
			wr_st_q <= wr_st_d;
			rd_st_q <= rd_st_d;
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			aw_addr_q <= aw_addr_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			awready <= awready_d;
			wready <= wready_d;
			bvalid <= bvalid_d;
			bresp <= bresp_d;
			arready <= arready_d;
			rvalid <= rvalid_d;
			rdata <= rdata_d;
			rresp <= rresp_d;
		end
	end

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	logic los_rd_clr, drv_rd_clr;

	assign los_rd_clr = rd_take && rd_idx == IDX_LOS_IRQ;
	assign drv_rd_clr = rd_take && rd_idx == IDX_DRV_IRQ;

	// status tracking, change latching, software writes, soft reset last
	always_comb begin
		los_en_d = los_en_q;
		drv_en_d = drv_en_q;
		mon_sel_d = mon_sel_q;
		loop_d = loop_q;
		std_d = std_q;
		ones_d = ones_q;
		e1_d = e1_q;
		for (int i = 0; i < NCH; i++) begin
			// a level counts once the second and third stages agree
			los_stat_d[i] = (los_s2_q[i] == los_s3_q[i]) ? los_s3_q[i] : los_stat_q[i];
			drv_stat_d[i] = (drv_s2_q[i] == drv_s3_q[i]) ? drv_s3_q[i] : drv_stat_q[i];
		end
		// new changes win over a clearing read
		los_irq_d = (los_stat_d ^ los_stat_q) | (los_rd_clr ? REG_RST : los_irq_q);
		drv_irq_d = (drv_stat_d ^ drv_stat_q) | (drv_rd_clr ? REG_RST : drv_irq_q);
		if (wr_fire && w_strb_q[0]) begin
			case (wr_idx)
				IDX_LOS_IRQ_EN: los_en_d = w_data_q[7:0];
				IDX_DRV_IRQ_EN: drv_en_d = w_data_q[7:0];
				IDX_MON_SEL: mon_sel_d = w_data_q[3:0]; // upper bits dropped
				IDX_LOOPBACK: loop_d = w_data_q[7:0];
				IDX_ALARM_STD: std_d = w_data_q[7:0];
				IDX_AUTO_ONES: ones_d = w_data_q[7:0];
				IDX_LINE_MODE: e1_d = w_data_q[MODE_E1_BIT];
				default: e1_d = e1_q;
			endcase
		end
		if (soft_rst) begin
			los_stat_d = REG_RST;
			drv_stat_d = REG_RST;
			los_irq_d = REG_RST;
			drv_irq_d = REG_RST;
			los_en_d = REG_RST;
			drv_en_d = REG_RST;
			mon_sel_d = 4'h0;
			loop_d = REG_RST;
			std_d = REG_RST;
			ones_d = REG_RST;
			e1_d = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			los_stat_q <= REG_RST;
			drv_stat_q <= REG_RST;
			los_irq_q <= REG_RST;
			drv_irq_q <= REG_RST;
			los_en_q <= REG_RST;
			drv_en_q <= REG_RST;
			mon_sel_q <= 4'h0;
			loop_q <= REG_RST;
			std_q <= REG_RST;
			ones_q <= REG_RST;
			e1_q <= 1'b0;
		end else begin
			los_stat_q <= los_stat_d;
			drv_stat_q <= drv_stat_d;
			los_irq_q <= los_irq_d;
			drv_irq_q <= drv_irq_d;
			los_en_q <= los_en_d;
			drv_en_q <= drv_en_d;
			mon_sel_q <= mon_sel_d;
			loop_q <= loop_d;
			std_q <= std_d;
			ones_q <= ones_d;
			e1_q <= e1_d;
		end
	end

	// ----------------------------------------
	// control outputs
	// ----------------------------------------
	logic irq_n_d, mon_en_d, mon_tx_d, t1_d;
	logic [7:0] ones_act_d, ets_d, tx_d;
	logic [2:0] mon_ch_d;

	// outputs follow the next register values so they line up with them
	always_comb begin
		irq_n_d = !((|(los_irq_d & los_en_d)) || (|(drv_irq_d & drv_en_d)));
		mon_en_d = mon_sel_d[2:0] != 3'h0;
		mon_tx_d = mon_en_d && mon_sel_d[MON_TX_BIT];
		mon_ch_d = mon_sel_d[2:0];
		t1_d = !e1_d;
		ets_d = e1_d ? std_d : REG_RST;
		ones_act_d = ones_d & los_stat_d;
		tx_d = tx_data_in | ones_act_d;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_n <= 1'b1;
			monitor_en <= 1'b0;
			monitor_tx <= 1'b0;
			monitor_ch <= 3'h0;
			alarm_t1_crit <= 1'b1;
			alarm_ets_sel <= REG_RST;
			all_ones_active <= REG_RST;
			tx_data_out <= REG_RST;
			loopback_en <= REG_RST;
		end else begin
			irq_n <= irq_n_d;
			monitor_en <= mon_en_d;
			monitor_tx <= mon_tx_d;
			monitor_ch <= mon_ch_d;
			alarm_t1_crit <= t1_d;
			alarm_ets_sel <= ets_d;
			all_ones_active <= ones_act_d;
			tx_data_out <= tx_d;
			loopback_en <= loop_d;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	logic soft_seen_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			soft_seen_q <= 1'b0;
		end else begin
			soft_seen_q <= soft_rst;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence soft_write_s;
		wr_fire && wr_idx == IDX_SOFT_RST;
	endsequence
	sequence all_clear_s;
		los_en_q == REG_RST && drv_en_q == REG_RST && los_irq_q == REG_RST && drv_irq_q == REG_RST
			&& loop_q == REG_RST && std_q == REG_RST && ones_q == REG_RST && mon_sel_q == 4'h0 && !e1_q;
	endsequence

	irq_gate_a: assert property (irq_n == !((|(los_irq_q & los_en_q)) || (|(drv_irq_q & drv_en_q))))
		else $error("irq_n does not match enabled irq bits");
	los_change_a: assert property (!soft_seen_q |-> ((los_stat_q ^ $past(los_stat_q)) & ~los_irq_q) == REG_RST)
		else $error("signal-loss change not latched");
	los_hold_a: assert property ((($past(los_irq_q) & ~los_irq_q) != REG_RST) |-> $past(los_rd_clr) || soft_seen_q)
		else $error("signal-loss irq bit dropped without clear");
	drv_change_a: assert property (!soft_seen_q |-> ((drv_stat_q ^ $past(drv_stat_q)) & ~drv_irq_q) == REG_RST)
		else $error("driver-fail change not latched");
	drv_hold_a: assert property ((($past(drv_irq_q) & ~drv_irq_q) != REG_RST) |-> $past(drv_rd_clr) || soft_seen_q)
		else $error("driver-fail irq bit dropped without clear");
	soft_reset_a: assert property (soft_write_s |=> bvalid ##0 all_clear_s)
		else $error("soft reset did not restore defaults");
	monitor_sel_a: assert property (monitor_en == (mon_sel_q[2:0] != 3'h0) && monitor_ch == mon_sel_q[2:0]
		&& monitor_tx == (monitor_en && mon_sel_q[MON_TX_BIT]))
		else $error("monitor select decode wrong");
	loopback_a: assert property (loopback_en == loop_q)
		else $error("loopback output differs from register");
	alarm_std_a: assert property (alarm_t1_crit == !e1_q && alarm_ets_sel == (e1_q ? std_q : REG_RST))
		else $error("alarm criteria select wrong");
	all_ones_a: assert property (all_ones_active == (ones_q & los_stat_q) && (all_ones_active & ~tx_data_out) == REG_RST)
		else $error("all-ones generation wrong");
	los_track_a: assert property ($past(los_s2_q) == $past(los_s3_q) && !soft_seen_q |-> los_stat_q == $past(los_s3_q))
		else $error("signal-loss status does not follow detector");
	read_answer_a: assert property (rd_take |=> rvalid && !arready)
		else $error("read not answered next cycle");
	// a clearing read keeps only the changes of its own cycle
	los_clear_a: assert property (los_rd_clr && !soft_rst |=> los_irq_q == (los_stat_q ^ $past(los_stat_q)))
		else $error("signal-loss irq bits not cleared by read");
	drv_clear_a: assert property (drv_rd_clr && !soft_rst |=> drv_irq_q == (drv_stat_q ^ $past(drv_stat_q)))
		else $error("driver-fail irq bits not cleared by read");

endmodule

// ### sim/lac_regs_tb.sv
`timescale 1ns/1ps
module lac_regs_tb
	import lac_pkg::*;
;
	logic aclk, aresetn;
	logic [7:0] awaddr, araddr, los_detect, short_detect, tx_data_in;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [7:0] tx_data_out, loopback_en, alarm_ets_sel, all_ones_active;
	logic irq_n, alarm_t1_crit, monitor_en, monitor_tx;
	logic [2:0] monitor_ch;
	int n_errors = 0;
	int n_checks = 0;
	logic [31:0] seed = 32'd78;
	logic [5:0] all_idx [12] = '{6'h04, 6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0a, 6'h0b, 6'h0c, 6'h0d,
		6'h0e, 6'h20};
	logic [5:0] rw_idx [6] = '{IDX_LOS_IRQ_EN, IDX_DRV_IRQ_EN, IDX_LOOPBACK, IDX_ALARM_STD, IDX_AUTO_ONES,
		IDX_MON_SEL};

	lac_regs lac_regs_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .los_detect(los_detect),
		.short_detect(short_detect), .tx_data_in(tx_data_in), .tx_data_out(tx_data_out), .irq_n(irq_n),
		.loopback_en(loopback_en), .alarm_ets_sel(alarm_ets_sel), .alarm_t1_crit(alarm_t1_crit),
		.all_ones_active(all_ones_active), .monitor_en(monitor_en), .monitor_tx(monitor_tx),
		.monitor_ch(monitor_ch));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// free-running clock, 4 ns period
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// xorshift source, low byte used as stimulus
	function automatic logic [7:0] rnd8();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction

	// expected {enable, transmit, channel} for a monitor code
	function automatic logic [4:0] mon_exp(input logic [3:0] c);
		logic en;
		en = |c[2:0];
		return {en, c[3] & en, en ? c[2:0] : 3'h0};
	endfunction

	task automatic stop_test();
		$display("checks %0d, errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic timed_out(input string what);
		n_errors++;
		$display("FAIL %0t: no answer on %s", $time, what);
		stop_test();
	endtask

	// one write: address and data offered together, each released when taken
	task automatic wr(input logic [5:0] idx, input logic [7:0] v, output logic [1:0] resp);
		bit aw_d, w_d;
		int i;
		aw_d = 0;
		w_d = 0;
		resp = 2'h3;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (!aw_d && awready === 1'b1) begin
				aw_d = 1;
				awvalid <= 1'b0;
			end
			if (!w_d && wready === 1'b1) begin
				w_d = 1;
				wvalid <= 1'b0;
			end
			if (aw_d && w_d && bvalid === 1'b1) begin
				resp = bresp;
				bready <= 1'b0;
				break;
			end
		end
		if (i == 40) timed_out("write");
	endtask

	// one read: held until taken, data taken at the rvalid edge
	task automatic rd(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] resp);
		bit ar_d;
		int i;
		ar_d = 0;
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (!ar_d && arready === 1'b1) begin
				ar_d = 1;
				arvalid <= 1'b0;
			end
			if (ar_d && rvalid === 1'b1) begin
				d = rdata;
				resp = rresp;
				rready <= 1'b0;
				break;
			end
		end
		if (i == 40) timed_out("read");
	endtask

	// detector change: status, latched change bits, gating, clear on read
	task automatic irq_case(input bit drv, input logic [7:0] en);
		logic [7:0] m, ao, t;
		logic [5:0] si, ei, ii;
		logic [31:0] d;
		logic [1:0] r;
		m = rnd8() | 8'h01;
		ao = rnd8();
		t = rnd8();
		si = drv ? IDX_DRV_STAT : IDX_LOS_STAT;
		ei = drv ? IDX_DRV_IRQ_EN : IDX_LOS_IRQ_EN;
		ii = drv ? IDX_DRV_IRQ : IDX_LOS_IRQ;
		wr(ei, en, r);
		wr(IDX_AUTO_ONES, ao, r);
		if (drv) short_detect <= m;
		else los_detect <= m;
		repeat (6) @(posedge aclk);
		rd(si, d, r);
		check(d, {24'h0, m}, "status");
		check({31'h0, irq_n}, {31'h0, ~|(m & en)}, "irq level");
		check({24'h0, all_ones_active}, {24'h0, drv ? 8'h00 : ao & m}, "all ones");
		tx_data_in <= t;
		repeat (2) @(posedge aclk);
		check({24'h0, tx_data_out}, {24'h0, t | (drv ? 8'h00 : ao & m)}, "tx out");
		tx_data_in <= 8'h00;
		if (drv) short_detect <= 8'h00;
		else los_detect <= 8'h00;
		repeat (6) @(posedge aclk);
		rd(ii, d, r);
		check(d, {24'h0, m}, "change bits held");
		rd(ii, d, r);
		check(d, 32'h0, "cleared by read");
		check({31'h0, irq_n}, 32'h1, "irq released");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [7:0] v [6];
		aresetn = 1'b0;
		{awaddr, araddr, wdata, los_detect, short_detect, tx_data_in} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'h1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (all_idx[k]) begin
			rd(all_idx[k], d, r);
			check(d, 32'h0, "reset value");
		end
		check({31'h0, alarm_t1_crit}, 32'h1, "t1 after reset");
		foreach (rw_idx[k]) begin
			v[k] = (rw_idx[k] == IDX_MON_SEL) ? rnd8() & 8'h0f : rnd8() | 8'h80;
			wr(rw_idx[k], v[k], r);
			rd(rw_idx[k], d, r);
			check(d, {24'h0, v[k]}, "read back");
		end
		check({24'h0, loopback_en}, {24'h0, v[2]}, "loopback");
		check({24'h0, alarm_ets_sel}, 32'h0, "t1 ignores standard");
		wr(IDX_LINE_MODE, 8'h01, r);
		check({24'h0, alarm_ets_sel}, {24'h0, v[3]}, "e1 standard");
		check({31'h0, alarm_t1_crit}, 32'h0, "e1 mode");
		wr(6'h3f, 8'h55, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write");
		rd(6'h3f, d, r);
		check({r, d[29:0]}, {RESP_SLVERR, 30'h0}, "unmapped read");
		wr(IDX_LOS_STAT, 8'hff, r);
		rd(IDX_LOS_STAT, d, r);
		check(d, 32'h0, "status not writable");
		for (int c = 0; c < 16; c++) begin
			wr(IDX_MON_SEL, 8'(c), r);
			check({27'h0, monitor_en, monitor_tx, monitor_en ? monitor_ch : 3'h0},
				{27'h0, mon_exp(4'(c))}, "monitor decode");
		end
		for (int i = 0; i < 6; i++) begin
			irq_case(i[0], (i < 2) ? 8'h00 : rnd8());
		end
		los_detect <= 8'h3c;
		repeat (6) @(posedge aclk);
		los_detect <= 8'h00;
		repeat (6) @(posedge aclk);
		wr(IDX_SOFT_RST, rnd8(), r);
		foreach (all_idx[k]) begin
			rd(all_idx[k], d, r);
			check(d, 32'h0, "after soft reset");
		end
		check({1'b0, irq_n, monitor_en, monitor_tx, monitor_ch, alarm_t1_crit, loopback_en, alarm_ets_sel,
			all_ones_active}, 32'h4100_0000, "outputs after soft reset");
		stop_test();
	end
endmodule
